/* File: acs_sequencer.sv */
// acs sequencer: AHB-Lite registers and conversion sequencing
`timescale 1ns/1ps
`default_nettype none
module acs_sequencer
  import acs_pkg::*;
(
  input  wire logic       sys_clk_i,
  input  wire logic       rst_b_i,
  input  wire logic       hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0] htrans_i,
  input  wire logic       hwrite_i,
  input  wire logic [2:0] hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic       hready_i,
  output logic            hreadyout_o,
  output logic            hresp_o,
  output logic [31:0]     hrdata_o,
  input  wire logic       event_i,
  input  wire logic       global_int_en_i,
  input  wire logic [9:0] conv_data_i,
  output var acs_conv_type conv_o,
  output logic            adc_clk_o,
  output logic            irq_o
);
  acs_seq_type s;
  acs_seq_type n;
  logic        scale_tick;
  logic        acc_ok;
  logic        rd_res;
  logic        cmd_set;
  logic        cmd_clr;
  logic        flag_clr;
  logic        evt_edge;
  logic        trig;
  logic        done;
  logic        last;
  logic        smp_end;
  logic        upd;
  logic [2:0]  acc_eff;
  logic [6:0]  smp_m1;
  logic [8:0]  tot_m1;
  logic [8:0]  hold_at;
  logic [15:0] smp_val;
  logic [8:0]  hlp_cyc_r;

  function automatic logic [31:0] rd_word(
    input acs_seq_type q,
    input logic [7:0]  a
  );
    logic [31:0] w;
    w = 32'h0000_0000;
    case (a)
      ACS_CTRL_OFS: begin
        w = acs_ctrl_pack(q.ctrl);
      end
      ACS_MUX_OFS: begin
        w[4:0] = q.ch_buf;
      end
      ACS_EVC_OFS: begin
        w[0] = q.evt_en;
      end
      ACS_CMD_OFS: begin
        w[0] = q.start;
      end
      ACS_IEN_OFS: begin
        w[0] = q.ie;
      end
      ACS_FLG_OFS: begin
        w[0] = q.flag;
      end
      ACS_RES_OFS: begin
        w[15:0] = q.res;
      end
      ACS_STS_OFS: begin
        w[0]              = q.start;
        w[ACS_STS_REF+:2] = q.ref_lk;
        w[ACS_STS_CH+:5]  = q.ch_lk;
      end
      default: begin
        w = 32'h0000_0000;
      end
    endcase
    return w;
  endfunction

  acs_prescaler u_scale (
    .sys_clk_i (sys_clk_i),
    .rst_b_i   (rst_b_i),
    .enable_i  (s.ctrl.enable),
    .run_i     (s.phase != ST_IDLE),
    .div_sel_i (s.ctrl.div_sel),
    .tick_o    (scale_tick),
    .adc_clk_o (adc_clk_o)
  );

  always_comb begin
    n = s;
    n.hold = 1'b0;
    cmd_set = 1'b0;
    cmd_clr = 1'b0;
    flag_clr = 1'b0;
    done = 1'b0;
    // bus address phase
    acc_ok = hsel_i & htrans_i[1] & hready_i & (hsize_i == ACS_HSIZE_WD);
    rd_res = acc_ok & ~hwrite_i & (haddr_i[7:0] == ACS_RES_OFS)
             & (haddr_i[31:8] == 24'h00_0000);
    n.dp_wr = acc_ok & hwrite_i;
    n.dp_addr = haddr_i[7:0];
    if (acc_ok && !hwrite_i && haddr_i[31:8] == 24'h00_0000) begin
      n.rdata = rd_word(s, haddr_i[7:0]);
    end else begin
      n.rdata = 32'h0000_0000;
    end
    // bus data phase
    if (s.dp_wr) begin
      case (s.dp_addr)
        ACS_CTRL_OFS: begin
          n.ctrl = acs_ctrl_unpack(hwdata_i);
        end
        ACS_MUX_OFS: begin
          n.ch_buf = hwdata_i[4:0];
        end
        ACS_EVC_OFS: begin
          n.evt_en = hwdata_i[0];
        end
        ACS_CMD_OFS: begin
          cmd_set = hwdata_i[0];
          cmd_clr = ~hwdata_i[0] & s.ctrl.free_run;
        end
        ACS_IEN_OFS: begin
          n.ie = hwdata_i[0];
        end
        ACS_FLG_OFS: begin
          flag_clr = hwdata_i[0];
        end
        default: begin
          n.ie = s.ie;
        end
      endcase
    end
    evt_edge = event_i & ~s.evt_prev;
    n.evt_prev = event_i;
    trig = s.ctrl.enable & (cmd_set | (s.evt_en & evt_edge));
    // sampling stretched by delay and length
    tot_m1 = ACS_BASE_M1 + 9'(s.ctrl.smp_dly) + 9'(s.ctrl.smp_len);
    hold_at = ACS_HOLD_M1 + 9'(s.ctrl.smp_dly) + 9'(s.ctrl.smp_len);
    acc_eff = (s.ctrl.accum > ACS_ACC_MAX) ? ACS_ACC_MAX : s.ctrl.accum;
    smp_m1 = 7'((8'h01 << acc_eff) - 8'h01);
    last = (s.smp == smp_m1);
    smp_end = (s.phase == ST_RUN) & (s.cyc >= tot_m1);
    if (s.ctrl.res_sel) begin
      smp_val = {8'h00, conv_data_i[ACS_RES_W-1:2]};
    end else begin
      smp_val = {6'h00, conv_data_i};
    end
    unique case (s.phase)
      ST_IDLE: begin
        if (trig) begin
          n.phase = ST_SYNC;
          n.start = 1'b1;
          n.stop = 1'b0;
          n.cyc = 9'h000;
          n.smp = 7'h00;
          n.acc = 16'h0000;
        end
      end
      ST_SYNC: begin
        // conversion begins on first divided edge
        if (scale_tick) begin
          n.phase = ST_RUN;
        end
      end
      ST_RUN: begin
        if (scale_tick) begin
          if (s.cyc == hold_at) begin
            n.hold = 1'b1;
          end
          if (smp_end) begin
            n.acc = s.acc + smp_val;
            n.cyc = 9'h000;
            if (last) begin
              done = 1'b1;
            end else begin
              n.smp = s.smp + 7'h01;
            end
          end else begin
            n.cyc = s.cyc + 9'h001;
          end
        end
      end
    endcase
    // start while busy leaves conversion alone
    if (s.phase != ST_IDLE) begin
      if (cmd_clr) begin
        n.stop = 1'b1;
      end else if (cmd_set) begin
        n.stop = 1'b0;
      end
    end
    if (done) begin
      n.res = s.acc + smp_val;
      n.acc = 16'h0000;
      n.smp = 7'h00;
      // restart only while start bit stays set
      if (s.ctrl.free_run && !s.stop && !cmd_clr) begin
        n.phase = ST_RUN;
      end else begin
        n.phase = ST_IDLE;
        n.start = 1'b0;
      end
    end
    // read or write one clears, set wins
    if (rd_res || flag_clr) begin
      n.flag = 1'b0;
    end
    // flag set regardless of irq enable
    if (done) begin
      n.flag = 1'b1;
    end
    // selections follow buffer only when safe
    upd = (s.phase == ST_IDLE) | (smp_end & last);
    // channel switch waits for conversion end
    if (upd) begin
      n.ch_lk = s.ch_buf;
      n.ref_lk = s.ctrl.ref_sel;
    end
    if (!s.ctrl.enable) begin
      n.phase = ST_IDLE;
      n.start = 1'b0;
      n.stop = 1'b0;
    end
    n.irq = s.flag & s.ie & global_int_en_i;
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s <= ACS_SEQ_RST;
    end else begin
      s <= n;
    end
  end

  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign hrdata_o = s.rdata;
  assign irq_o = s.irq;
  assign conv_o = '{sample:  s.hold,
                    busy:    s.start,
                    res8:    s.ctrl.res_sel,
                    ref_sel: s.ref_lk,
                    channel: s.ch_lk};

  // converter clocks since start of the current sample
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hlp_cyc_r <= 9'h000;
    end else if (scale_tick && (s.phase == ST_SYNC || smp_end)) begin
      hlp_cyc_r <= 9'h000;
    end else if (scale_tick) begin
      hlp_cyc_r <= hlp_cyc_r + 9'h001;
    end
  end

  default clocking acs_cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  busy_start_a:
    assert property (s.phase != ST_IDLE |-> s.start)
    else $error("start bit low during conversion");

  single_clear_a:
    assert property (done && !s.ctrl.free_run |=> !s.start && s.phase == ST_IDLE)
    else $error("single conversion did not clear start bit");

  chan_lock_a:
    assert property (s.phase != ST_IDLE && !$past(upd) |-> $stable(s.ch_lk))
    else $error("channel changed during conversion");

  ref_lock_a:
    assert property (s.phase != ST_IDLE && !$past(upd) |-> $stable(s.ref_lk))
    else $error("reference changed during conversion");

  flag_done_a:
    assert property (done |=> s.flag ##1 (s.flag || $past(rd_res || flag_clr)))
    else $error("result flag not set after completion");

  irq_gate_a:
    assert property (s.flag && s.ie && global_int_en_i |=> irq_o)
    else $error("interrupt not raised");

  event_start_a:
    assert property (s.phase == ST_IDLE && s.ctrl.enable && s.evt_en && evt_edge
                     |=> s.start && s.phase == ST_SYNC)
    else $error("event did not start conversion");

  free_run_a:
    assert property (done && s.ctrl.free_run && !s.stop && !cmd_clr && s.ctrl.enable
                     |=> s.phase == ST_RUN && s.cyc == 9'h000 && s.start)
    else $error("free-running conversion not restarted");

  conv_len_a:
    assert property (done |-> hlp_cyc_r == ACS_BASE_M1 + 9'(s.ctrl.smp_dly)
                                           + 9'(s.ctrl.smp_len))
    else $error("conversion length wrong");

  hold_time_a:
    assert property (s.hold |-> hlp_cyc_r == ACS_HOLD_CYC + 9'(s.ctrl.smp_dly)
                                             + 9'(s.ctrl.smp_len))
    else $error("sample-and-hold at wrong cycle");

  idle_scale_a:
    assert property (s.phase == ST_IDLE |=> !scale_tick)
    else $error("prescaler ran while idle");

  busy_ignore_a:
    assert property (s.phase == ST_RUN && trig && !scale_tick |=> s.cyc == $past(s.cyc))
    else $error("trigger disturbed running conversion");

  disable_a:
    assert property (!s.ctrl.enable |=> s.phase == ST_IDLE && !s.start)
    else $error("sequencer busy while disabled");
endmodule
`default_nettype wire

/* File: acs_pkg.sv */
// acs package: register map, field layout, timing constants and types
`default_nettype none
package acs_pkg;
  localparam int unsigned ACS_AW       = 8;
  localparam logic [7:0]  ACS_CTRL_OFS = 8'h00;
  localparam logic [7:0]  ACS_MUX_OFS  = 8'h04;
  localparam logic [7:0]  ACS_EVC_OFS  = 8'h08;
  localparam logic [7:0]  ACS_CMD_OFS  = 8'h0c;
  localparam logic [7:0]  ACS_IEN_OFS  = 8'h10;
  localparam logic [7:0]  ACS_FLG_OFS  = 8'h14;
  localparam logic [7:0]  ACS_RES_OFS  = 8'h18;
  localparam logic [7:0]  ACS_STS_OFS  = 8'h1c;
  localparam int unsigned ACS_EN_POS   = 0;
  localparam int unsigned ACS_FREE_POS = 1;
  localparam int unsigned ACS_RES_POS  = 2;
  localparam int unsigned ACS_ACC_POS  = 4;
  localparam int unsigned ACS_DIV_POS  = 8;
  localparam int unsigned ACS_REF_POS  = 12;
  localparam int unsigned ACS_DLY_POS  = 16;
  localparam int unsigned ACS_LEN_POS  = 24;
  localparam int unsigned ACS_STS_CH   = 8;
  localparam int unsigned ACS_STS_REF  = 4;
  localparam logic [2:0]  ACS_HSIZE_WD = 3'h2;
  localparam logic [8:0]  ACS_BASE_M1  = 9'h00c;
  localparam logic [8:0]  ACS_HOLD_M1  = 9'h001;
  localparam logic [8:0]  ACS_HOLD_CYC = 9'h002;
  localparam logic [2:0]  ACS_ACC_MAX  = 3'h6;
  localparam int unsigned ACS_RES_W    = 10;

  typedef enum logic [1:0] {ST_IDLE, ST_SYNC, ST_RUN} acs_phase_type;

  typedef struct packed {
    logic [7:0] smp_len;
    logic [3:0] smp_dly;
    logic [1:0] ref_sel;
    logic [2:0] div_sel;
    logic [2:0] accum;
    logic       res_sel;
    logic       free_run;
    logic       enable;
  } acs_ctrl_type;

  typedef struct packed {
    logic       sample;
    logic       busy;
    logic       res8;
    logic [1:0] ref_sel;
    logic [4:0] channel;
  } acs_conv_type;

  typedef struct packed {
    acs_phase_type phase;
    logic [8:0]    cyc;
    logic [6:0]    smp;
    logic [15:0]   acc;
    acs_ctrl_type  ctrl;
    logic [4:0]    ch_buf;
    logic [4:0]    ch_lk;
    logic [1:0]    ref_lk;
    logic          evt_en;
    logic          start;
    logic          stop;
    logic          ie;
    logic          flag;
    logic          irq;
    logic [15:0]   res;
    logic          evt_prev;
    logic          hold;
    logic          dp_wr;
    logic [7:0]    dp_addr;
    logic [31:0]   rdata;
  } acs_seq_type;

  typedef struct packed {
    logic [7:0] cnt;
    logic       clk;
    logic       tick;
  } acs_scale_type;

  localparam acs_seq_type   ACS_SEQ_RST   = '0;
  localparam acs_scale_type ACS_SCALE_RST = '0;

  function automatic acs_ctrl_type acs_ctrl_unpack(input logic [31:0] w);
    acs_ctrl_type r;
    r.enable   = w[ACS_EN_POS];
    r.free_run = w[ACS_FREE_POS];
    r.res_sel  = w[ACS_RES_POS];
    r.accum    = w[ACS_ACC_POS+:3];
    r.div_sel  = w[ACS_DIV_POS+:3];
    r.ref_sel  = w[ACS_REF_POS+:2];
    r.smp_dly  = w[ACS_DLY_POS+:4];
    r.smp_len  = w[ACS_LEN_POS+:8];
    return r;
  endfunction

  function automatic logic [31:0] acs_ctrl_pack(input acs_ctrl_type c);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[ACS_EN_POS]       = c.enable;
    w[ACS_FREE_POS]     = c.free_run;
    w[ACS_RES_POS]      = c.res_sel;
    w[ACS_ACC_POS+:3]   = c.accum;
    w[ACS_DIV_POS+:3]   = c.div_sel;
    w[ACS_REF_POS+:2]   = c.ref_sel;
    w[ACS_DLY_POS+:4]   = c.smp_dly;
    w[ACS_LEN_POS+:8]   = c.smp_len;
    return w;
  endfunction
endpackage
`default_nettype wire

/* File: acs_prescaler.sv */
// acs prescaler: converter clock and edge tick from the peripheral clock
`timescale 1ns/1ps
`default_nettype none
module acs_prescaler
  import acs_pkg::*;
(
  input  wire logic       sys_clk_i,
  input  wire logic       rst_b_i,
  input  wire logic       enable_i,
  input  wire logic       run_i,
  input  wire logic [2:0] div_sel_i,
  output logic            tick_o,
  output logic            adc_clk_o
);
  acs_scale_type s;
  acs_scale_type n;
  logic [7:0]    half_m1;
  logic [7:0]    full_m1;

  always_comb begin
    n = s;
    n.tick = 1'b0;
    half_m1 = 8'((9'h001 << div_sel_i) - 9'h001);
    full_m1 = 8'((9'h002 << div_sel_i) - 9'h001);
    if (!enable_i || !run_i) begin
      n = ACS_SCALE_RST;
    end else begin
      // divide by two to the select plus one
      n.cnt = (s.cnt == full_m1) ? 8'h00 : s.cnt + 8'h01;
      if (s.cnt == half_m1) begin
        n.tick = 1'b1;
        n.clk  = 1'b1;
      end
      if (s.cnt == full_m1) begin
        n.clk = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s <= ACS_SCALE_RST;
    end else begin
      s <= n;
    end
  end

  assign tick_o    = s.tick;
  assign adc_clk_o = s.clk;
endmodule
`default_nettype wire

/* File: acs_core_model.sv */
// converter core model: returns a channel-coded value to the sequencer
`timescale 1ns/1ps
`default_nettype none
module acs_core_model
  import acs_pkg::*;
(
  input  wire logic         sys_clk_i,
  input  wire logic         rst_b_i,
  input  wire acs_conv_type conv_i,
  output logic [9:0]        conv_data_o
);
  logic [9:0] held_r;

  // value captured at the sample pulse, 10 bits wide
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      held_r <= 10'h000;
    end else if (conv_i.sample) begin
      held_r <= {conv_i.channel, conv_i.ref_sel, 3'h5};
    end
  end

  // released outside a conversion: shows the inverse
  assign conv_data_o = conv_i.busy ? held_r : ~held_r;
endmodule
`default_nettype wire

/* File: tb_adc_conversion_sequencer.sv */
// testbench: register-driven conversion scenarios for the sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_adc_conversion_sequencer
  import acs_pkg::*;
;
  logic             sys_clk_i;
  logic             rst_b_i;
  logic             hsel;
  logic [31:0]      haddr;
  logic [1:0]       htrans;
  logic             hwrite;
  logic [2:0]       hsize;
  logic [31:0]      hwdata;
  logic             event_i;
  logic             glob_en;
  wire logic        hready;
  wire logic        hresp;
  wire logic [31:0] hrdata;
  wire logic [9:0]  conv_data;
  wire logic        adc_clk;
  wire logic        irq;
  acs_conv_type     conv;
  logic [31:0]      rd;
  int               errors = 0;
  int               tests_run = 0;
  int               bcnt = 0;
  int               scnt = 0;
  int               b0;
  int               s0;
  int               d0;
  logic [7:0]       amap [6];

  acs_sequencer i_dut (
    .sys_clk_i       (sys_clk_i),
    .rst_b_i         (rst_b_i),
    .hsel_i          (hsel),
    .haddr_i         (haddr),
    .htrans_i        (htrans),
    .hwrite_i        (hwrite),
    .hsize_i         (hsize),
    .hwdata_i        (hwdata),
    .hready_i        (hready),
    .hreadyout_o     (hready),
    .hresp_o         (hresp),
    .hrdata_o        (hrdata),
    .event_i         (event_i),
    .global_int_en_i (glob_en),
    .conv_data_i     (conv_data),
    .conv_o          (conv),
    .adc_clk_o       (adc_clk),
    .irq_o           (irq)
  );

  acs_core_model i_core (
    .sys_clk_i   (sys_clk_i),
    .rst_b_i     (rst_b_i),
    .conv_i      (conv),
    .conv_data_o (conv_data)
  );

  initial begin
    sys_clk_i = 1'b0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end

  // busy cycles and sample pulses seen at the core side
  always @(posedge sys_clk_i) begin
    if (conv.busy === 1'b1) bcnt = bcnt + 1;
    if (conv.sample === 1'b1) scnt = scnt + 1;
  end

  function automatic logic [31:0] code(input logic [4:0] ch, input logic [1:0] rf);
    return {22'h0, ch, rf, 3'h5};
  endfunction

  task automatic give_verdict();
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h000000, a};
    hwrite <= wr;
    hsize  <= ACS_HSIZE_WD;
    do @(posedge sys_clk_i); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    if (wr) hwdata <= d;
    do @(posedge sys_clk_i); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string m);
    bus(1'b0, a, 32'h0);
    chk(rd, exp, m);
  endtask

  task automatic wait_conv();
    do @(posedge sys_clk_i); while (conv.busy !== 1'b1);
    do @(posedge sys_clk_i); while (conv.busy !== 1'b0);
    @(negedge sys_clk_i);
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk_i);
    errors++;
    give_verdict();
  end

  initial begin
    amap = '{ACS_CTRL_OFS, ACS_MUX_OFS, ACS_FLG_OFS, ACS_RES_OFS, ACS_STS_OFS, 8'h40};
    rst_b_i = 1'b0;
    hsel    = 1'b0;
    haddr   = 32'h0;
    htrans  = 2'h0;
    hwrite  = 1'b0;
    hsize   = 3'h0;
    hwdata  = 32'h0;
    event_i = 1'b0;
    glob_en = 1'b0;
    repeat (10) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    foreach (amap[i]) rdc(amap[i], 32'h0, "reset value");
    // single conversion, channel change while busy, repeated start
    bus(1'b1, ACS_MUX_OFS, 32'h5);
    bus(1'b1, ACS_IEN_OFS, 32'h1);
    bus(1'b1, ACS_CTRL_OFS, 32'h1);
    b0 = bcnt;
    s0 = scnt;
    bus(1'b1, ACS_CMD_OFS, 32'h1);
    rdc(ACS_CMD_OFS, 32'h1, "start bit while busy");
    bus(1'b1, ACS_MUX_OFS, 32'h9);
    rdc(ACS_STS_OFS, 32'h0000_0501, "locked channel");
    bus(1'b1, ACS_CMD_OFS, 32'h1);
    wait_conv();
    d0 = bcnt - b0;
    chk(32'(d0 >= 28 && d0 <= 29), 32'h1, "base conversion length");
    chk(32'(scnt - s0), 32'h1, "one sample pulse");
    chk({31'h0, irq}, 32'h0, "irq with global off");
    rdc(ACS_CMD_OFS, 32'h0, "start bit cleared");
    rdc(ACS_FLG_OFS, 32'h1, "flag set");
    @(posedge sys_clk_i);
    glob_en <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    chk({31'h0, irq}, 32'h1, "irq raised");
    rdc(ACS_RES_OFS, code(5'd5, 2'd0), "result old channel");
    rdc(ACS_FLG_OFS, 32'h0, "flag cleared by read");
    chk({31'h0, hresp}, 32'h0, "response okay");
    chk({31'h0, adc_clk}, 32'h0, "converter clock idle");
    // event start, second edge while busy, polling with irq off
    bus(1'b1, ACS_IEN_OFS, 32'h0);
    bus(1'b1, ACS_EVC_OFS, 32'h1);
    b0 = bcnt;
    @(posedge sys_clk_i);
    event_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    event_i <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    event_i <= 1'b1;
    wait_conv();
    chk(32'(bcnt - b0), 32'(d0), "event conversion length");
    chk({31'h0, irq}, 32'h0, "no irq when disabled");
    rdc(ACS_FLG_OFS, 32'h1, "flag set without irq");
    bus(1'b1, ACS_FLG_OFS, 32'h1);
    rdc(ACS_FLG_OFS, 32'h0, "flag cleared by write");
    rdc(ACS_RES_OFS, code(5'd9, 2'd0), "result new channel");
    @(posedge sys_clk_i);
    event_i <= 1'b0;
    // divide by 4, delay 2, length 3, four accumulated samples
    bus(1'b1, ACS_CTRL_OFS, 32'h0302_2121);
    b0 = bcnt;
    s0 = scnt;
    bus(1'b1, ACS_CMD_OFS, 32'h1);
    wait_conv();
    chk(32'(bcnt - b0), 32'(d0 + 263), "scaled conversion length");
    chk(32'(scnt - s0), 32'h4, "accumulated samples");
    rdc(ACS_RES_OFS, code(5'd9, 2'd2) << 2, "accumulated result");
    // divide by 256 keeps the converter clock in range; 8-bit result
    bus(1'b1, ACS_CTRL_OFS, 32'h0000_1705);
    @(negedge sys_clk_i);
    chk({31'h0, conv.res8}, 32'h1, "resolution select driven");
    b0 = bcnt;
    bus(1'b1, ACS_CMD_OFS, 32'h1);
    repeat (200) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    chk({31'h0, adc_clk}, 32'h1, "converter clock high half");
    wait_conv();
    chk(32'(bcnt - b0), 32'(128 + 1 + 13 * 256), "divide by 256 length");
    rdc(ACS_RES_OFS, code(5'd9, 2'd1) >> 2, "8-bit right-adjusted result");
    // free-running until the start bit is written to 0
    bus(1'b1, ACS_CTRL_OFS, 32'h3);
    s0 = scnt;
    bus(1'b1, ACS_CMD_OFS, 32'h1);
    do @(posedge sys_clk_i); while (scnt - s0 < 3);
    bus(1'b1, ACS_CMD_OFS, 32'h0);
    wait_conv();
    rdc(ACS_CMD_OFS, 32'h0, "free run stopped");
    rdc(ACS_FLG_OFS, 32'h1, "free run completions");
    // disabled block: divider stopped, start refused
    bus(1'b1, ACS_CTRL_OFS, 32'h0);
    repeat (4) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    chk({31'h0, adc_clk}, 32'h0, "divider held when disabled");
    bus(1'b1, ACS_CMD_OFS, 32'h1);
    rdc(ACS_CMD_OFS, 32'h0, "start refused when disabled");
    give_verdict();
  end
endmodule
`default_nettype wire
